// file: inc/sbdtc_pkg.sv
// Timing constants and helper functions for the SCSI bus controller
package sbdtc_pkg;

  // ---------------------------------------------------------------
  // Local clock
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;

  // ---------------------------------------------------------------
  // Bus timing figures in their own units
  // ---------------------------------------------------------------
  localparam int ARB_DELAY_NS = 2400;
  localparam int BUS_CLEAR_NS = 800;
  localparam int BUS_FREE_NS = 800;
  localparam int BUS_SET_NS = 1800;
  localparam int BUS_SETTLE_NS = 400;
  localparam int DATA_REL_NS = 400;
  localparam int RST_HOLD_US = 25;
  localparam int SEL_ABORT_US = 200;
  localparam int SEL_TIMEOUT_MS = 250;
  localparam int ASSERT_NS = 90;
  localparam int NEGATE_NS = 90;
  localparam int HOLD_NS = 45;
  localparam int FAST_ASSERT_NS = 30;
  localparam int FAST_NEGATE_NS = 30;
  localparam int FAST_HOLD_NS = 10;
  localparam int FAST_LIMIT_NS = 200;

  // ---------------------------------------------------------------
  // Cycle conversion: minimums round up, maximums round down
  // ---------------------------------------------------------------
  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_max(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ARB_DELAY_CYC = cyc_min(ARB_DELAY_NS);
  localparam int BUS_CLEAR_CYC = cyc_max(BUS_CLEAR_NS);
  localparam int BUS_FREE_CYC = cyc_min(BUS_FREE_NS);
  localparam int BUS_SET_CYC = cyc_max(BUS_SET_NS);
  localparam int BUS_SETTLE_CYC = cyc_min(BUS_SETTLE_NS);
  localparam int DATA_REL_CYC = cyc_max(DATA_REL_NS);
  localparam int RST_HOLD_CYC = cyc_min(RST_HOLD_US * 1000);
  localparam int SEL_ABORT_CYC = cyc_max(SEL_ABORT_US * 1000);
  localparam int SEL_TIMEOUT_CYC = cyc_min(SEL_TIMEOUT_MS * 1000000);
  localparam int ASSERT_CYC = cyc_min(ASSERT_NS);
  localparam int NEGATE_CYC = cyc_min(NEGATE_NS);
  localparam int HOLD_CYC = cyc_min(HOLD_NS);
  localparam int FAST_ASSERT_CYC = cyc_min(FAST_ASSERT_NS);
  localparam int FAST_NEGATE_CYC = cyc_min(FAST_NEGATE_NS);
  localparam int FAST_HOLD_CYC = cyc_min(FAST_HOLD_NS);

  // ---------------------------------------------------------------
  // Bus ID helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] id_mask(input logic [2:0] id);
    return 8'h01 << id;
  endfunction

  function automatic logic [2:0] hi_bit(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

endpackage

// file: design/sbdtc_delay_timer.sv
// Down counter used for protocol delays
`timescale 1ns/100ps
module sbdtc_delay_timer #(
  parameter int CNT_W = 22
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Control
  input wire logic start,
  input wire logic [CNT_W-1:0] load,
  // Status
  output logic done,
  output logic [CNT_W-1:0] count
);
  logic [CNT_W-1:0] count_r;

  assign done = (count_r == '0);
  assign count = count_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_r <= '0;
    end else if (start) begin
      count_r <= load;
    end else if (!done) begin
      count_r <= count_r - 1'b1;
    end
  end
endmodule

// file: design/sbdtc_bus_ctrl.sv
// SCSI initiator bus controller: arbitration, selection, transfer, reset
`timescale 1ns/100ps
module sbdtc_bus_ctrl #(
  parameter int CNT_W = 22,
  parameter int SEL_TO_CYC = sbdtc_pkg::SEL_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // User control
  input wire logic [2:0] ownId,
  input wire logic [2:0] targetId,
  input wire logic startSel,
  input wire logic atnReq,
  input wire logic busRstReq,
  input wire logic syncEn,
  input wire logic [9:0] syncPeriodNs,
  input wire logic [7:0] txData,
  // User status
  output logic [7:0] rxData,
  output logic rxValid,
  output logic txTaken,
  output logic selDone,
  output logic selTimeout,
  output logic arbLost,
  output logic connected,
  output logic [2:0] busPhase,
  // OR-tied control pins
  input wire logic bsyIn,
  output logic bsyOut,
  output logic bsyOeN,
  input wire logic selIn,
  output logic selOut,
  output logic selOeN,
  input wire logic rstIn,
  output logic rstOut,
  output logic rstOeN,
  // Initiator-owned pins
  output logic atnOut,
  output logic atnOeN,
  output logic ackOut,
  output logic ackOeN,
  // Target-owned pins, sampled only
  input wire logic reqIn,
  input wire logic ioIn,
  input wire logic cdIn,
  input wire logic msgIn,
  // Data bus and parity
  input wire logic [7:0] dbIn,
  output logic [7:0] dbOut,
  output logic [7:0] dbOeN,
  input wire logic parIn,
  output logic parOut,
  output logic parOeN
);
  import sbdtc_pkg::*;

  if (CNT_W < $clog2(SEL_TO_CYC + 1) || SEL_TO_CYC < 1) begin : g_chk
    $error("CNT_W too narrow for selection time-out");
  end

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [15:0] syncA_r, syncB_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA_r <= 16'h0000;
      syncB_r <= 16'h0000;
    end else begin
      syncA_r <= {parIn, bsyIn, selIn, rstIn, reqIn, ioIn, cdIn, msgIn, dbIn};
      syncB_r <= syncA_r;
    end
  end
  wire [7:0] dbS = syncB_r[7:0];
  wire msgS = syncB_r[8];
  wire cdS = syncB_r[9];
  wire ioS = syncB_r[10];
  wire reqS = syncB_r[11];
  wire rstS = syncB_r[12];
  wire selS = syncB_r[13];
  wire bsyS = syncB_r[14];

  // ---------------------------------------------------------------
  // Bus free detection
  // ---------------------------------------------------------------
  logic [7:0] freeCnt_r;
  wire busFree = (freeCnt_r == 8'(BUS_SETTLE_CYC));
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      freeCnt_r <= 8'h00;
    end else if (bsyS || selS) begin
      freeCnt_r <= 8'h00;
    end else if (!busFree) begin
      freeCnt_r <= freeCnt_r + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Main state machine
  // ---------------------------------------------------------------
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001, ST_FREE_DLY = 10'h002, ST_ARB = 10'h004,
    ST_SEL_ASSERT = 10'h008, ST_SEL_ID = 10'h010, ST_SEL_WAIT = 10'h020,
    ST_SEL_END = 10'h040, ST_RESEL = 10'h080, ST_CONNECT = 10'h100,
    ST_RST_HOLD = 10'h200
  } sbdtc_state_e;

  sbdtc_state_e state_r, state_nxt;
  logic tmrStart, tmrDone;
  logic [CNT_W-1:0] tmrLoad, tmrCount;
  logic selPend_r;

  sbdtc_delay_timer #(.CNT_W(CNT_W)) u_timer (
    .clk(clk), .sys_rst(sys_rst), .start(tmrStart), .load(tmrLoad),
    .done(tmrDone), .count(tmrCount)
  );

  wire [7:0] ownMask = id_mask(ownId);
  wire [7:0] tgtMask = id_mask(targetId);
  wire arbWin = (hi_bit(dbS) == ownId) && !selS;
  wire reselDet = selS && ioS && !bsyS && ((dbS & ownMask) != 8'h00);
  wire bsyValid = (CNT_W'(SEL_TO_CYC) - tmrCount) > CNT_W'(BUS_SETTLE_CYC);

  always_comb begin
    state_nxt = state_r;
    tmrStart = 1'b0;
    tmrLoad = '0;
    if (busRstReq && state_r != ST_RST_HOLD) begin
      state_nxt = ST_RST_HOLD;
      tmrStart = 1'b1;
      tmrLoad = CNT_W'(RST_HOLD_CYC);
    end else if (rstS && state_r != ST_RST_HOLD) begin
      state_nxt = ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (reselDet) begin
            state_nxt = ST_RESEL;
          end else if (selPend_r && busFree) begin
            state_nxt = ST_FREE_DLY;
            tmrStart = 1'b1;
            tmrLoad = CNT_W'(BUS_FREE_CYC);
          end
        end
        ST_FREE_DLY: begin
          if (!busFree) begin
            state_nxt = ST_IDLE;
          end else if (tmrDone) begin
            state_nxt = ST_ARB;
            tmrStart = 1'b1;
            tmrLoad = CNT_W'(ARB_DELAY_CYC);
          end
        end
        ST_ARB: begin
          if (selS || (tmrDone && !arbWin)) begin
            state_nxt = ST_IDLE;
          end else if (tmrDone) begin
            state_nxt = ST_SEL_ASSERT;
            tmrStart = 1'b1;
            tmrLoad = CNT_W'(BUS_SETTLE_CYC);
          end
        end
        ST_SEL_ASSERT, ST_SEL_ID: begin
          if (tmrDone) begin
            state_nxt = (state_r == ST_SEL_ASSERT) ? ST_SEL_ID : ST_SEL_WAIT;
            tmrStart = 1'b1;
            tmrLoad = (state_r == ST_SEL_ASSERT) ? CNT_W'(BUS_SETTLE_CYC)
                                                 : CNT_W'(SEL_TO_CYC);
          end
        end
        ST_SEL_WAIT: begin
          if (bsyS && bsyValid) begin
            state_nxt = ST_SEL_END;
            tmrStart = 1'b1;
            tmrLoad = CNT_W'(BUS_SETTLE_CYC);
          end else if (tmrDone) begin
            state_nxt = ST_IDLE;
          end
        end
        ST_SEL_END: begin
          if (tmrDone) begin
            state_nxt = ST_CONNECT;
          end
        end
        ST_RESEL: begin
          if (!selS) begin
            state_nxt = ST_CONNECT;
          end
        end
        ST_CONNECT: begin
          if (busFree) begin
            state_nxt = ST_IDLE;
          end
        end
        ST_RST_HOLD: begin
          if (tmrDone && !busRstReq) begin
            state_nxt = ST_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Drive decode per phase
  // ---------------------------------------------------------------
  wire inSel = state_nxt inside {ST_SEL_ASSERT, ST_SEL_ID, ST_SEL_WAIT, ST_SEL_END};
  wire bsyNxt = state_nxt inside {ST_ARB, ST_SEL_ASSERT, ST_SEL_ID, ST_RESEL};
  wire selNxt = inSel;
  wire atnNxt = atnReq && (state_nxt inside {ST_SEL_ID, ST_SEL_WAIT, ST_SEL_END,
                                            ST_CONNECT});
  wire inConn = (state_r == ST_CONNECT) && (state_nxt == ST_CONNECT);

  // ---------------------------------------------------------------
  // Transfer handshake timing
  // ---------------------------------------------------------------
  // fast set below limit
  wire fastMode = syncPeriodNs < 10'(FAST_LIMIT_NS);
  wire [7:0] asrCyc = fastMode ? 8'(FAST_ASSERT_CYC) : 8'(ASSERT_CYC);
  wire [7:0] negCyc = fastMode ? 8'(FAST_NEGATE_CYC) : 8'(NEGATE_CYC);
  wire [7:0] perCyc = 8'(cyc_min(int'(syncPeriodNs)));
  wire [7:0] gapCyc = (perCyc > asrCyc + negCyc) ? 8'(perCyc - asrCyc) : negCyc;

  logic reqPrev_r, ackPend_r, ackDrv_r, atnDrv_r, bsyDrv_r, selDrv_r, rstDrv_r;
  logic [7:0] ackCnt_r, dbVal_r, dbDrv_r, rxData_r;
  logic rxValid_r, txTaken_r, selDone_r, selTimeout_r, arbLost_r;
  logic [2:0] phase_r;
  wire reqRise = reqS && !reqPrev_r && inConn && !ackPend_r && !ackDrv_r
                 && (ackCnt_r == 8'h00);
  wire ackEnd = ackDrv_r && (syncEn ? (ackCnt_r <= 8'h01) : !reqS);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reqPrev_r <= 1'b0;
      ackPend_r <= 1'b0;
      ackDrv_r <= 1'b0;
      ackCnt_r <= 8'h00;
    end else begin
      reqPrev_r <= reqS;
      ackPend_r <= reqRise;
      if (!inConn) begin
        ackDrv_r <= 1'b0;
        ackCnt_r <= 8'h00;
      end else if (ackPend_r) begin
        ackDrv_r <= 1'b1;
        ackCnt_r <= asrCyc;
      end else if (ackEnd) begin
        ackDrv_r <= 1'b0;
        ackCnt_r <= syncEn ? gapCyc : 8'h00;
      end else if (ackCnt_r != 8'h00) begin
        ackCnt_r <= ackCnt_r - 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Pin drive registers and user status
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      bsyDrv_r <= 1'b0;
      selDrv_r <= 1'b0;
      rstDrv_r <= 1'b0;
      atnDrv_r <= 1'b0;
      dbVal_r <= 8'h00;
      dbDrv_r <= 8'h00;
      selPend_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bsyDrv_r <= bsyNxt;
      selDrv_r <= selNxt;
      rstDrv_r <= (state_nxt == ST_RST_HOLD);
      atnDrv_r <= atnNxt;
      if (startSel) begin
        selPend_r <= 1'b1;
      end else if (state_nxt inside {ST_SEL_END, ST_RST_HOLD} || rstS) begin
        selPend_r <= 1'b0;
      end else if (state_r == ST_SEL_WAIT && state_nxt == ST_IDLE) begin
        selPend_r <= 1'b0;
      end
      if (state_nxt == ST_ARB) begin
        dbVal_r <= ownMask;
        dbDrv_r <= ownMask;
      end else if (state_nxt inside {ST_SEL_ID, ST_SEL_WAIT, ST_SEL_END}) begin
        dbVal_r <= ownMask | tgtMask;
        dbDrv_r <= 8'hFF;
      end else if (inConn && !ioS) begin
        if (reqRise) begin
          dbVal_r <= txData;
          dbDrv_r <= 8'hFF;
        end
      end else begin
        dbDrv_r <= 8'h00;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rxData_r <= 8'h00;
      rxValid_r <= 1'b0;
      txTaken_r <= 1'b0;
      selDone_r <= 1'b0;
      selTimeout_r <= 1'b0;
      arbLost_r <= 1'b0;
      phase_r <= 3'h0;
    end else begin
      rxValid_r <= reqRise && ioS;
      txTaken_r <= reqRise && !ioS;
      if (reqRise && ioS) begin
        rxData_r <= dbS;
      end
      selDone_r <= (state_r == ST_SEL_END) && (state_nxt == ST_CONNECT);
      selTimeout_r <= (state_r == ST_SEL_WAIT) && (state_nxt == ST_IDLE) && !rstS;
      arbLost_r <= (state_r == ST_ARB) && (state_nxt == ST_IDLE) && !rstS;
      phase_r <= {msgS, cdS, ioS};
    end
  end

  // ---------------------------------------------------------------
  // Output mapping (enable low drives)
  // ---------------------------------------------------------------
  assign bsyOut = 1'b1;
  assign bsyOeN = ~bsyDrv_r;
  assign selOut = 1'b1;
  assign selOeN = ~selDrv_r;
  assign rstOut = 1'b1;
  assign rstOeN = ~rstDrv_r;
  assign atnOut = 1'b1;
  assign atnOeN = ~atnDrv_r;
  assign ackOut = 1'b1;
  assign ackOeN = ~ackDrv_r;
  assign dbOut = dbVal_r;
  assign dbOeN = ~dbDrv_r;
  assign parOut = ~^dbVal_r;
  assign parOeN = ~((dbDrv_r == 8'hFF) && (state_r != ST_ARB));
  assign rxData = rxData_r;
  assign rxValid = rxValid_r;
  assign txTaken = txTaken_r;
  assign selDone = selDone_r;
  assign selTimeout = selTimeout_r;
  assign arbLost = arbLost_r;
  assign connected = (state_r == ST_CONNECT);
  assign busPhase = phase_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  localparam int CLR_MAX = BUS_CLEAR_CYC;
  localparam int DREL_MAX = DATA_REL_CYC;
  localparam int SET_MAX = BUS_SET_CYC;
  logic [8:0] rstAge_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rstAge_r <= 9'h000;
    end else if (!rstDrv_r) begin
      rstAge_r <= 9'h000;
    end else if (rstAge_r != 9'h1FF) begin
      rstAge_r <= rstAge_r + 9'h001;
    end
  end
  sequence s_arbStart;
    $rose(state_r == ST_ARB);
  endsequence
  sequence s_freeSeen;
    $rose(state_r == ST_FREE_DLY);
  endsequence

  AST_ARB_DRIVE: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_ARB) |-> bsyDrv_r && (dbDrv_r == ownMask))
    else $error("Arbitration drive pattern wrong");
  AST_PAR_ARB: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_ARB) |-> parOeN)
    else $error("Parity driven during arbitration");
  AST_IDLE_REL: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_IDLE) && $past(state_r == ST_IDLE)
      |-> bsyOeN && selOeN && ackOeN && atnOeN && (dbOeN == 8'hFF))
    else $error("Signal driven while idle");
  AST_SEL_WIN: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(selDrv_r) |-> $past(state_r == ST_ARB) && $past(arbWin))
    else $error("SEL asserted without winning");
  AST_ARB_WAIT: assert property (@(posedge clk) disable iff (sys_rst)
    s_arbStart |-> !selDrv_r [*8])
    else $error("Arbitration judged too early");
  AST_FREE_DLY: assert property (@(posedge clk) disable iff (sys_rst)
    s_arbStart |-> $past(state_r == ST_FREE_DLY, BUS_FREE_CYC))
    else $error("BSY asserted before bus free delay");
  AST_SET_DLY: assert property (@(posedge clk) disable iff (sys_rst)
    s_freeSeen ##1 (busFree && !rstS && !busRstReq) [*8]
      |-> ##[1:SET_MAX] (bsyDrv_r && (dbDrv_r == ownMask)))
    else $error("BSY not asserted within bus set delay");
  AST_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_CONNECT) && busFree && !busRstReq
      |-> ##[1:CLR_MAX] (bsyOeN && selOeN && ackOeN && (dbOeN == 8'hFF)))
    else $error("Bus not cleared in time");
  AST_DATA_REL: assert property (@(posedge clk) disable iff (sys_rst)
    connected && $rose(ioS) |-> ##[1:DREL_MAX] (dbOeN == 8'hFF))
    else $error("Data not released after I/O rise");
  AST_RST_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(rstDrv_r) |-> $past(rstAge_r) >= 9'(RST_HOLD_CYC))
    else $error("Bus reset released too early");
  AST_RESEL: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == ST_IDLE) && reselDet && !busRstReq && !rstS |-> ##1 bsyDrv_r)
    else $error("No BSY answer to reselection");
  AST_DATA_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    ackDrv_r && $past(ackDrv_r) && !ioS |-> $stable(dbVal_r))
    else $error("Data changed while ACK asserted");
endmodule

// file: testbench/sbdtc_target_model.sv
// Behavioural SCSI target: answers selection, sends one byte
`timescale 1ns/100ps
module sbdtc_target_model (
  // Control
  input wire logic clk,
  input wire logic [2:0] myId,
  input wire logic respond,
  input wire logic [7:0] inByte,
  // Resolved bus
  input wire logic bsyBus,
  input wire logic selBus,
  input wire logic ackBus,
  input wire logic [7:0] dbBus,
  // Target drivers
  output logic tBsy,
  output logic tReq,
  output logic tIo,
  output logic [7:0] tDb
);
  initial begin
    {tBsy, tReq, tIo, tDb} = '0;
    forever begin
      @(negedge clk);
      if (respond && selBus && !bsyBus && dbBus[myId]) begin
        repeat (3) @(negedge clk);
        tBsy = 1'b1;
        while (selBus) @(negedge clk);
        tIo = 1'b1;
        repeat (6) @(negedge clk);
        tDb = inByte;
        repeat (2) @(negedge clk);
        tReq = 1'b1;
        while (!ackBus) @(negedge clk);
        tReq = 1'b0;
        while (ackBus) @(negedge clk);
        tDb = 8'h00;
        tIo = 1'b0;
        repeat (2) @(negedge clk);
        tBsy = 1'b0;
      end
    end
  end
endmodule

// file: testbench/test_scsi_bus_driver_timing_control.sv
// Self-checking bench for the SCSI initiator bus controller
`timescale 1ns/100ps
module test_scsi_bus_driver_timing_control;
  import sbdtc_pkg::*;
  localparam int SELTO = 200;
  logic clk, sys_rst, startSel, busRstReq, respond, inArb;
  logic [2:0] ownId, targetId, busPhase;
  logic [7:0] txData, inByte, rxData, dbOut, dbOeN, tDb;
  logic rxValid, txTaken, selDone, selTimeout, arbLost, connected;
  logic bsyOut, bsyOeN, selOut, selOeN, rstOut, rstOeN, atnOut, atnOeN;
  logic ackOut, ackOeN, parOut, parOeN, tBsy, tReq, tIo;
  int fail_count, n_checks;
  int arbCnt = 0;
  int selCnt = 0;
  int rstCnt = 0;
  wire logic bsyBus = ~bsyOeN | tBsy;
  wire logic [7:0] dbBus = (~dbOeN & dbOut) | tDb;
  wire logic allRel = &{bsyOeN, selOeN, rstOeN, atnOeN, ackOeN, dbOeN, parOeN};

  sbdtc_bus_ctrl #(.SEL_TO_CYC(SELTO)) dut (
    .clk, .sys_rst, .ownId, .targetId, .startSel, .atnReq(1'b0), .busRstReq,
    .syncEn(1'b0), .syncPeriodNs(10'h0C8), .txData, .rxData, .rxValid,
    .txTaken, .selDone, .selTimeout, .arbLost, .connected, .busPhase,
    .bsyIn(bsyBus), .bsyOut, .bsyOeN, .selIn(~selOeN), .selOut, .selOeN,
    .rstIn(~rstOeN), .rstOut, .rstOeN, .atnOut, .atnOeN, .ackOut, .ackOeN,
    .reqIn(tReq), .ioIn(tIo), .cdIn(1'b0), .msgIn(1'b0), .dbIn(dbBus),
    .dbOut, .dbOeN, .parIn(~parOeN & parOut), .parOut, .parOeN
  );

  sbdtc_target_model tgt (
    .clk, .myId(targetId), .respond, .inByte, .bsyBus, .selBus(~selOeN),
    .ackBus(~ackOeN), .dbBus, .tBsy, .tReq, .tIo, .tDb
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  function automatic logic sig(input int k);
    case (k)
      0: return selDone;
      1: return selTimeout;
      2: return rxValid;
      3: return !connected;
      default: return allRel;
    endcase
  endfunction

  task automatic waitHi(input int k, input int n);
    for (int i = 0; i < n && sig(k) !== 1'b1; i++) begin
      @(negedge clk);
    end
    if (sig(k) !== 1'b1) begin
      fail_count++;
      end_of_test();
    end
  endtask

  // ---------------------------------------------------------------
  // Bus monitor
  // ---------------------------------------------------------------
  always @(posedge clk) begin
    arbCnt <= (inArb && !bsyOeN) ? arbCnt + 1 : 0;
    selCnt <= inArb ? 0 : selCnt + int'(!selOeN);
    rstCnt <= rstCnt + int'(!rstOeN);
    if (inArb && !bsyOeN && selOeN) begin
      chk(32'(~dbOeN & dbOut), 32'(8'h01 << ownId));
      chk(32'(parOeN | parOut), 32'h1);
    end
    if (inArb && !selOeN) begin
      chk(32'(arbCnt >= ARB_DELAY_CYC), 32'h1);
      inArb <= 1'b0;
    end
    if (tReq && tIo) chk(32'(dbOeN), 32'hFF);
    if (!ackOeN) chk(32'(connected), 32'h1);
    chk(32'({arbLost, atnOeN}), 32'h1);
  end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    {startSel, busRstReq, respond, inArb} = '0;
    fail_count = 0;
    n_checks = 0;
    ownId = 3'h7;
    targetId = 3'h2;
    txData = 8'h00;
    inByte = 8'h00;
    sys_rst = 1'b1;
    void'($urandom(35322));
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk(32'(allRel), 32'h1);
    for (int k = 0; k < 4; k++) begin
      ownId = 3'($urandom_range(7));
      targetId = ownId + 3'(1 + $urandom_range(6));
      inByte = (k == 0) ? 8'hFF : 8'($urandom);
      txData = 8'($urandom);
      respond = (k != 1);
      inArb = 1'b1;
      startSel = 1'b1;
      @(negedge clk);
      startSel = 1'b0;
      waitHi(respond ? 0 : 1, 800);
      if (respond) begin
        waitHi(2, 100);
        chk(32'(rxData), 32'(inByte));
        chk(32'({txTaken, busPhase}), 32'h1);
      end else begin
        chk(32'(selCnt >= SELTO), 32'h1);
      end
      waitHi(3, 80);
      waitHi(4, 10);
    end
    busRstReq = 1'b1;
    @(negedge clk);
    busRstReq = 1'b0;
    repeat (3) @(negedge clk);
    waitHi(4, 400);
    chk(32'(rstCnt >= RST_HOLD_CYC), 32'h1);
    end_of_test();
  end
endmodule
